// ---- common/elpc_defs.svh ----
// Constants for the encoder latch and preset control block
`ifndef ELPC_DEFS_SVH
`define ELPC_DEFS_SVH

`define ELPC_CB_ZERO_EN     0
`define ELPC_CB_RISE_EN     1
`define ELPC_CB_PRESET      2
`define ELPC_CB_FALL_EN     3

`define ELPC_SB_ZERO_VALID  0
`define ELPC_SB_EXT_VALID   1
`define ELPC_SB_PRESET_ACC  2
`define ELPC_SB_UNDERFLOW   3
`define ELPC_SB_OVERFLOW    4
`define ELPC_SB_INPUT       5

`define ELPC_CTRL_RESET     8'h00
`define ELPC_COUNT_RESET    16'h0000
`define ELPC_COUNT_MAX      16'hffff
`define ELPC_OVF_CLEAR_AT   16'h5555
`define ELPC_UNF_CLEAR_AT   16'haaaa

`endif

// ---- common/elpc_pkg.sv ----
// Types for the encoder latch and preset control block
package elpc_pkg;
    typedef logic [15:0] elpc_count_t;
    typedef logic [7:0]  elpc_byte_t;
endpackage : elpc_pkg

// ---- verilog/elpc_latch_ctrl.sv ----
// Latch and preset control of a 16-bit incremental encoder counter
`timescale 1ns/1ps
`default_nettype none
`include "elpc_defs.svh"
// Overview of operation
// - Control byte: fall, preset, rise, zero enables
// - Falling ext edge captures once while enabled
// - Rising ext edge captures once while enabled
// - Ext capture only while ext valid low
// - Preset rising edge loads counter from preset
// - First C pulse after enable saves count
// - Zero-point latch beats external latches
// - Zero capture only while zero valid low
// - Zero valid clears only while C low
// - Status bits flag captures; value readable
// - Status bit 2 acknowledges accepted preset
// - Overflow/underflow flags set on wraps, cleared past one/two thirds or on the opposite wrap
module elpc_latch_ctrl (
    input  wire logic                clk,            // 40 MHz system clock
    input  wire logic                sys_rst,        // Async reset, active high
    input  wire elpc_pkg::elpc_byte_t control_byte,  // Control byte from controller
    input  wire logic                control_valid,  // Pulse: new control byte
    input  wire elpc_pkg::elpc_count_t preset_value, // Counter preset value
    input  wire logic                count_up,       // Pulse: count up one step
    input  wire logic                count_down,     // Pulse: count down one step
    input  wire logic                enc_c,          // Encoder C track
    input  wire logic                ext_latch_in,   // External latch input
    output var  elpc_pkg::elpc_count_t counter_value,   // Counter
    output var  elpc_pkg::elpc_count_t latch_value,     // Captured counter value
    output var  elpc_pkg::elpc_byte_t  status_byte      // Status byte
);
    import elpc_pkg::*;

    elpc_byte_t  ctrl,       next_ctrl;
    elpc_count_t count,      next_count;
    elpc_count_t latch,      next_latch;
    logic        zero_valid, next_zero_valid;
    logic        ext_valid,  next_ext_valid;
    logic        preset_acc, next_preset_acc;
    logic        ovf,        next_ovf;
    logic        unf,        next_unf;
    logic        c_prev,     ext_prev;

    logic        zero_en, rise_en, fall_en;
    logic        preset_edge, zero_cap, ext_cap, c_rise, ext_rise, ext_fall;
    logic        step_up, step_down;

    // Enables follow the most recent control byte
    assign zero_en     = ctrl[`ELPC_CB_ZERO_EN];
    assign rise_en     = ctrl[`ELPC_CB_RISE_EN];
    assign fall_en     = ctrl[`ELPC_CB_FALL_EN];
    assign preset_edge = control_valid && control_byte[`ELPC_CB_PRESET]
                         && !ctrl[`ELPC_CB_PRESET];

    assign c_rise   = enc_c && !c_prev;
    assign ext_rise = ext_latch_in && !ext_prev;
    assign ext_fall = !ext_latch_in && ext_prev;

    assign zero_cap = zero_en && c_rise && !zero_valid;
    // Zero latch armed blocks external capture into the shared register
    assign ext_cap  = !zero_en && !ext_valid
                      && ((rise_en && ext_rise) || (fall_en && ext_fall));

    assign step_up   = count_up && !count_down && !preset_edge;
    assign step_down = count_down && !count_up && !preset_edge;

    always_comb begin
        next_ctrl       = control_valid ? control_byte : ctrl;
        next_count      = count;
        next_latch      = latch;
        next_zero_valid = zero_valid;
        next_ext_valid  = ext_valid;
        next_preset_acc = preset_acc;
        next_ovf        = ovf;
        next_unf        = unf;
        if (preset_edge) begin
            next_count      = preset_value;
            next_preset_acc = 1'b1;
        end else if (step_up) begin
            next_count = count + 16'h0001;
        end else if (step_down) begin
            next_count = count - 16'h0001;
        end
        if (control_valid && !control_byte[`ELPC_CB_PRESET]) begin
            next_preset_acc = 1'b0;
        end
        if (step_up && count == `ELPC_COUNT_MAX) begin
            next_ovf = 1'b1;
            next_unf = 1'b0;
        end else if (step_up && count == `ELPC_OVF_CLEAR_AT) begin
            next_ovf = 1'b0;
        end
        if (step_down && count == `ELPC_COUNT_RESET) begin
            next_unf = 1'b1;
            next_ovf = 1'b0;
        end else if (step_down && count == `ELPC_UNF_CLEAR_AT) begin
            next_unf = 1'b0;
        end
        // Valid drops only once the enable is withdrawn
        if (!zero_en && !enc_c) begin
            next_zero_valid = 1'b0;
        end
        if (!rise_en && !fall_en) begin
            next_ext_valid = 1'b0;
        end
        if (zero_cap) begin
            next_latch      = count;
            next_zero_valid = 1'b1;
        end else if (ext_cap) begin
            next_latch     = count;
            next_ext_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl       <= `ELPC_CTRL_RESET;
            count      <= `ELPC_COUNT_RESET;
            latch      <= `ELPC_COUNT_RESET;
            zero_valid <= 1'b0;
            ext_valid  <= 1'b0;
            preset_acc <= 1'b0;
            ovf        <= 1'b0;
            unf        <= 1'b0;
            c_prev     <= 1'b0;
            ext_prev   <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            count      <= next_count;
            latch      <= next_latch;
            zero_valid <= next_zero_valid;
            ext_valid  <= next_ext_valid;
            preset_acc <= next_preset_acc;
            ovf        <= next_ovf;
            unf        <= next_unf;
            c_prev     <= enc_c;
            ext_prev   <= ext_latch_in;
        end
    end

    assign counter_value = count;
    assign latch_value   = latch;
    always_comb begin
        status_byte                      = 8'h00;
        status_byte[`ELPC_SB_ZERO_VALID] = zero_valid;
        status_byte[`ELPC_SB_EXT_VALID]  = ext_valid;
        status_byte[`ELPC_SB_PRESET_ACC] = preset_acc;
        status_byte[`ELPC_SB_UNDERFLOW]  = unf;
        status_byte[`ELPC_SB_OVERFLOW]   = ovf;
        status_byte[`ELPC_SB_INPUT]      = ext_prev;
    end

    sequence s_zero_arm;
        zero_en && !zero_valid ##0 enc_c && !c_prev;
    endsequence

    sequence s_zero_saved;
        zero_valid && latch_value == $past(counter_value);
    endsequence

    chk_preset_load: assert property (@(posedge clk) disable iff (sys_rst)
        preset_edge |=> counter_value == $past(preset_value))
        else $error("Preset edge did not load counter");

    chk_preset_ack_bit: assert property (@(posedge clk) disable iff (sys_rst)
        preset_edge ##1 !control_valid |-> status_byte[`ELPC_SB_PRESET_ACC])
        else $error("Preset not acknowledged");

    chk_zero_capture: assert property (@(posedge clk) disable iff (sys_rst)
        s_zero_arm |=> s_zero_saved)
        else $error("Zero-point latch missed first C pulse");

    chk_zero_hold: assert property (@(posedge clk) disable iff (sys_rst)
        zero_valid && zero_en |=> $stable(latch_value))
        else $error("Zero latch value overwritten while valid");

    chk_zero_clear_c: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(status_byte[`ELPC_SB_ZERO_VALID]) |-> !$past(enc_c))
        else $error("Zero valid cleared while C high");

    chk_ext_rise_cap: assert property (@(posedge clk) disable iff (sys_rst)
        rise_en && !zero_en && !ext_valid && ext_latch_in && !ext_prev
        |=> ext_valid && latch_value == $past(counter_value))
        else $error("Rising external latch not captured");

    chk_ext_fall_cap: assert property (@(posedge clk) disable iff (sys_rst)
        fall_en && !zero_en && !ext_valid && !ext_latch_in && ext_prev
        |=> ext_valid && latch_value == $past(counter_value))
        else $error("Falling external latch not captured");

    chk_ext_hold: assert property (@(posedge clk) disable iff (sys_rst)
        ext_valid && !zero_cap |=> $stable(latch_value))
        else $error("External latch value overwritten while valid");

    chk_zero_priority: assert property (@(posedge clk) disable iff (sys_rst)
        zero_en && !zero_cap |=> !$rose(ext_valid))
        else $error("External latch captured while zero latch armed");

    chk_overflow_set: assert property (@(posedge clk) disable iff (sys_rst)
        step_up && counter_value == 16'hffff |=> status_byte[`ELPC_SB_OVERFLOW]
        && !status_byte[`ELPC_SB_UNDERFLOW] && counter_value == 16'h0000)
        else $error("Overflow not flagged on wrap");

    chk_underflow_set: assert property (@(posedge clk) disable iff (sys_rst)
        step_down && counter_value == 16'h0000 |=> status_byte[`ELPC_SB_UNDERFLOW]
        && !status_byte[`ELPC_SB_OVERFLOW] && counter_value == 16'hffff)
        else $error("Underflow not flagged on wrap");

    chk_overflow_clear: assert property (@(posedge clk) disable iff (sys_rst)
        step_up && counter_value == `ELPC_OVF_CLEAR_AT |=> !status_byte[`ELPC_SB_OVERFLOW])
        else $error("Overflow flag kept past one third");

    chk_underflow_clear: assert property (@(posedge clk) disable iff (sys_rst)
        step_down && counter_value == `ELPC_UNF_CLEAR_AT |=> !status_byte[`ELPC_SB_UNDERFLOW])
        else $error("Underflow flag kept past two thirds");

    chk_preset_refused: assert property (@(posedge clk) disable iff (sys_rst)
        control_valid && control_byte[`ELPC_CB_PRESET] && ctrl[`ELPC_CB_PRESET]
        && !count_up && !count_down |=> $stable(counter_value))
        else $error("Preset reloaded without a new edge");

    chk_preset_ack_drop: assert property (@(posedge clk) disable iff (sys_rst)
        control_valid && !control_byte[`ELPC_CB_PRESET]
        |=> !status_byte[`ELPC_SB_PRESET_ACC])
        else $error("Preset acknowledge kept after strobe cleared");

endmodule : elpc_latch_ctrl
`default_nettype wire

// ---- sim/elpc_ctrl_model.sv ----
// Controller model sending control bytes and preset values
`timescale 1ns/1ps
`default_nettype none
module elpc_ctrl_model (
    input  wire logic                  clk,           // System clock
    output var  elpc_pkg::elpc_byte_t  control_byte,  // Control byte
    output var  logic                  control_valid, // New byte pulse
    output var  elpc_pkg::elpc_count_t preset_value   // Preset value
);
    import elpc_pkg::*;
    initial begin
        control_byte = 8'h00;
        control_valid = 1'b0;
        preset_value = 16'h0000;
    end
    // Idle byte lines show garbage
    task automatic send(input elpc_byte_t b, input elpc_count_t p);
        @(posedge clk);
        control_byte <= b;
        control_valid <= 1'b1;
        preset_value <= p;
        @(posedge clk);
        control_valid <= 1'b0;
        control_byte <= ~b;
    endtask : send
endmodule : elpc_ctrl_model
`default_nettype wire

// ---- sim/encoder_latch_preset_control_bench.sv ----
// Bench for the encoder latch and preset control block
`timescale 1ns/1ps
`default_nettype none
module encoder_latch_preset_control_bench;
    import elpc_pkg::*;
    logic        clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        control_valid, count_up = 0, count_down = 0, enc_c = 0, ext = 0;
    elpc_byte_t  control_byte, status_byte, m_ctl, m_sb;
    elpc_count_t preset_value, counter_value, latch_value, m_cnt, m_lat;
    logic        pc, pe;
    logic [16:0] wrap [4] = '{17'h1ffff, 17'h15555, 17'h00000, 17'h0aaaa};
    logic [31:0] r;
    integer      seed = 92247;
    integer      miscompares = 0;
    integer      n_checks = 0;
    always #12.5 clk = ~clk;
    elpc_ctrl_model i_elpc_ctrl_model (.clk(clk), .control_byte(control_byte),
        .control_valid(control_valid), .preset_value(preset_value));
    elpc_latch_ctrl i_elpc_latch_ctrl (.clk(clk), .sys_rst(sys_rst),
        .control_byte(control_byte), .control_valid(control_valid),
        .preset_value(preset_value), .count_up(count_up), .count_down(count_down),
        .enc_c(enc_c), .ext_latch_in(ext), .counter_value(counter_value),
        .latch_value(latch_value), .status_byte(status_byte));
    // Reference model, updated from the inputs seen at each edge
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {m_ctl, m_cnt, m_lat, m_sb, pc, pe} = '0;
        end else begin
            if (m_ctl[0] && enc_c && !pc && !m_sb[0]) begin
                m_lat = m_cnt;
                m_sb[0] = 1'b1;
            end else if (!m_ctl[0] && !enc_c) m_sb[0] = 1'b0;
            if (!m_ctl[0] && !m_sb[1] && (m_ctl[1] && ext && !pe || m_ctl[3] && !ext && pe)) begin
                m_lat = m_cnt;
                m_sb[1] = 1'b1;
            end else if (!m_ctl[1] && !m_ctl[3]) m_sb[1] = 1'b0;
            if (control_valid && control_byte[2] && !m_ctl[2]) begin
                m_cnt = preset_value;
                m_sb[2] = 1'b1;
            end else if (count_up && !count_down) begin
                if (m_cnt == 16'hffff) m_sb[4:3] = 2'b10;
                if (m_cnt == 16'h5555) m_sb[4] = 1'b0;
                m_cnt = m_cnt + 16'h0001;
            end else if (count_down && !count_up) begin
                if (m_cnt == 16'h0000) m_sb[4:3] = 2'b01;
                if (m_cnt == 16'haaaa) m_sb[3] = 1'b0;
                m_cnt = m_cnt - 16'h0001;
            end
            if (control_valid && !control_byte[2]) m_sb[2] = 1'b0;
            if (control_valid) m_ctl = control_byte;
            m_sb[5] = ext;
            pc = enc_c;
            pe = ext;
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    always @(negedge clk) if (!sys_rst) begin
        chk("counter_value", m_cnt, counter_value);
        chk("latch_value", m_lat, latch_value);
        chk("status_byte", {8'h00, m_sb}, {8'h00, status_byte});
    end
    task automatic cyc(input logic [3:0] v);
        @(posedge clk);
        {count_up, count_down, enc_c, ext} <= v;
    endtask : cyc
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        foreach (wrap[k]) begin
            i_elpc_ctrl_model.send(8'h04, wrap[k][15:0]);
            i_elpc_ctrl_model.send(8'h00, 16'h0000);
            cyc({wrap[k][16], ~wrap[k][16], 2'b00});
            cyc(4'h0);
        end
        $display("Test wrap flags done");
        // Arm, clear, re-arm the zero latch with extra pulses
        repeat (2) begin
            i_elpc_ctrl_model.send(8'h01, 16'h0000);
            cyc(4'h2);
            cyc(4'h8);
            cyc(4'h2);
            i_elpc_ctrl_model.send(8'h0a, 16'h0000);
            cyc(4'h1);
            cyc(4'h0);
        end
        // Falling-edge latch captures once, then ignores the next fall
        i_elpc_ctrl_model.send(8'h00, 16'h0000);
        cyc(4'h1);
        i_elpc_ctrl_model.send(8'h08, 16'h0000);
        cyc(4'h0);
        cyc(4'h1);
        cyc(4'h0);
        $display("Test latch re-arm done");
        repeat (3000) begin
            r = $random(seed);
            if (r[7:4] == 4'h0) i_elpc_ctrl_model.send(r[15:8], r[31:16]);
            cyc(r[3:0]);
        end
        $display("Test random traffic done");
        // Mid-run reset clears count, latch and status
        cyc(4'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("reset_count", 16'h0000, counter_value);
        chk("reset_latch", 16'h0000, latch_value);
        chk("reset_status", 16'h0000, {8'h00, status_byte});
        i_elpc_ctrl_model.send(8'h04, 16'h1234);
        cyc(4'h0);
        $display("Test mid-run reset done");
        summarize();
    end
    initial begin
        #500000;
        miscompares++;
        summarize();
    end
endmodule : encoder_latch_preset_control_bench
`default_nettype wire
